/* File: src/vendor_cmd_regs.sv */
// vendor command registers: target address, settings crc, fault injection
// Overview of operation
// - new written address takes effect at once, old address abandoned
// - transactions to the former address are not acknowledged
// - address register uses single-byte write and single-byte read
// - address bit 7 reads zero and ignores writes
// - low seven bits hold address, loaded from store or straps
// - reserved addresses 0x0C 0x28 0x37 0x61 are refused
// - crc register holds crc-16 poly 0x8005 over stored settings
// - crc recomputed at boot and after each store or restore
// - crc register is 16-bit read-only, word read
// - injection bits force their detector outputs; word read and write
// - several injection bits act together
// - persist bits keep injections; otherwise cleared after one response
// - with conversion off only input-off and output-overvoltage act
`timescale 1ns/10ps
module vendor_cmd_regs
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        boot,
  input  wire logic        use_strap,
  input  wire logic [6:0]  strap_addr,
  input  wire logic [6:0]  nvm_addr,
  input  wire logic        nvm_done,
  output logic [3:0]       nvm_rd_idx,
  input  wire logic [7:0]  nvm_rd_data,
  input  wire logic        bus_start,
  input  wire logic [6:0]  bus_target,
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  input  wire logic [7:0]  cmd_code,
  input  wire logic        cmd_word,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic        conv_en,
  input  wire logic        fault_response,
  input  wire logic        warn_response,
  output logic             addr_ack,
  output logic [15:0]      cmd_rdata,
  output logic             cmd_ok,
  output logic             addr_ff_out,
  output logic [15:0]      crc_value,
  output logic             crc_busy,
  output logic [15:0]      detector_force
);
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_DONE = 3'b100
  } crc_state_t;

  logic [6:0]  addr_ff, nxt_addr;
  logic [15:0] inject_ff, nxt_inject;
  logic [15:0] crc_ff, nxt_crc;
  logic [15:0] acc_ff, nxt_acc;
  logic [3:0]  idx_ff, nxt_idx;
  crc_state_t  st_ff, nxt_st;
  logic        ack_ff, nxt_ack;
  logic [15:0] rdata_ff, nxt_rdata;
  logic        ok_ff, nxt_ok;
  logic [15:0] force_ff, nxt_force;
  logic        boot_ld_ff;
  logic        crc_busy_ff, nxt_busy;
  logic [15:0] crc_step;
  logic        addr_bad;

  crc16_step crc16_step_inst
  (
    .crc_in  (acc_ff),
    .data_in (nvm_rd_data),
    .crc_out (crc_step)
  );

  assign addr_bad = (cmd_wdata[6:0] == vendor_regs_pkg::RSV_ADDR_0) ||
                    (cmd_wdata[6:0] == vendor_regs_pkg::RSV_ADDR_1) ||
                    (cmd_wdata[6:0] == vendor_regs_pkg::RSV_ADDR_2) ||
                    (cmd_wdata[6:0] == vendor_regs_pkg::RSV_ADDR_3);

  // register writes and reads
  always_comb
  begin
    logic [15:0] live;
    live       = inject_ff;
    nxt_addr   = addr_ff;
    nxt_inject = inject_ff;
    nxt_rdata  = rdata_ff;
    nxt_ok     = 1'b0;
    nxt_ack    = ack_ff;
    if (boot)
      nxt_addr = use_strap ? strap_addr : nvm_addr;
    if (bus_start)
      nxt_ack = (bus_target == addr_ff);
    // injections drop after one response unless persisted
    if (fault_response && !inject_ff[vendor_regs_pkg::BIT_FAULT_PERS])
      live = live & ~vendor_regs_pkg::FAULT_MASK;
    if (warn_response && !inject_ff[vendor_regs_pkg::BIT_WARN_PERS])
      live = live & ~vendor_regs_pkg::WARN_MASK;
    nxt_inject = live;
    if (cmd_wr)
    begin
      unique case (cmd_code)
        vendor_regs_pkg::CMD_ADDRESS:
        begin
          if (!cmd_word)
          begin
            nxt_ok = !addr_bad;
            if (!addr_bad)
              nxt_addr = cmd_wdata[6:0];
          end
        end
        vendor_regs_pkg::CMD_INJECT:
        begin
          if (cmd_word)
          begin
            nxt_ok     = 1'b1;
            nxt_inject = cmd_wdata & vendor_regs_pkg::INJECT_WMASK;
          end
        end
        default: nxt_ok = 1'b0;
      endcase
    end
    else if (cmd_rd)
    begin
      unique case (cmd_code)
        vendor_regs_pkg::CMD_ADDRESS:
        begin
          nxt_ok    = !cmd_word;
          nxt_rdata = {8'h00, 1'b0, addr_ff};
        end
        vendor_regs_pkg::CMD_CRC:
        begin
          nxt_ok    = cmd_word;
          nxt_rdata = crc_ff;
        end
        vendor_regs_pkg::CMD_INJECT:
        begin
          nxt_ok    = cmd_word;
          nxt_rdata = inject_ff;
        end
        default:
        begin
          nxt_ok    = 1'b0;
          nxt_rdata = 16'h0000;
        end
      endcase
    end
    // every selected detector is forced together, one cycle after its injection bit is set, while conversion is on
    nxt_force = inject_ff & (vendor_regs_pkg::FAULT_MASK | vendor_regs_pkg::WARN_MASK);
    if (!conv_en)
      nxt_force = nxt_force & vendor_regs_pkg::OFF_ALLOWED;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      addr_ff   <= 7'h00;
      inject_ff <= vendor_regs_pkg::INJECT_RESET;
      ack_ff    <= 1'b0;
      rdata_ff  <= 16'h0000;
      ok_ff     <= 1'b0;
      force_ff  <= 16'h0000;
    end
    else
    begin
      addr_ff   <= nxt_addr;
      inject_ff <= nxt_inject;
      ack_ff    <= nxt_ack;
      rdata_ff  <= nxt_rdata;
      ok_ff     <= nxt_ok;
      force_ff  <= nxt_force;
    end
  end

  // crc walk over the stored settings
  always_comb
  begin
    nxt_st  = st_ff;
    nxt_acc = acc_ff;
    nxt_idx = idx_ff;
    nxt_crc = crc_ff;
    unique case (st_ff)
      ST_IDLE:
      begin
        if (boot_ld_ff || nvm_done)
        begin
          nxt_st  = ST_RUN;
          nxt_acc = vendor_regs_pkg::CRC_INIT;
          nxt_idx = 4'h0;
        end
      end
      ST_RUN:
      begin
        nxt_acc = crc_step;
        nxt_idx = idx_ff + 4'h1;
        if (idx_ff == vendor_regs_pkg::NVM_LAST)
          nxt_st = ST_DONE;
      end
      ST_DONE:
      begin
        nxt_crc = acc_ff;
        nxt_st  = ST_IDLE;
      end
      default: nxt_st = ST_IDLE;
    endcase
    nxt_busy = (nxt_st != ST_IDLE);
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff      <= ST_IDLE;
      acc_ff     <= vendor_regs_pkg::CRC_INIT;
      idx_ff     <= 4'h0;
      crc_ff     <= vendor_regs_pkg::CRC_INIT;
      boot_ld_ff <= 1'b0;
      crc_busy_ff <= 1'b0;
    end
    else
    begin
      st_ff      <= nxt_st;
      acc_ff     <= nxt_acc;
      idx_ff     <= nxt_idx;
      crc_ff     <= nxt_crc;
      boot_ld_ff <= boot;
      crc_busy_ff <= nxt_busy;
    end
  end

  assign nvm_rd_idx     = idx_ff;
  assign addr_ack       = ack_ff;
  assign cmd_rdata      = rdata_ff;
  assign cmd_ok         = ok_ff;
  assign addr_ff_out    = addr_ff[0];
  assign crc_value      = crc_ff;
  assign crc_busy       = crc_busy_ff;
  assign detector_force = force_ff;

  // checks
  addr_reserved_a: assert property (@(posedge clock) disable iff (!nrst)
    cmd_wr && !cmd_word && cmd_code == vendor_regs_pkg::CMD_ADDRESS && addr_bad && !boot
    |=> addr_ff == $past(addr_ff)) else $error("reserved address was accepted");
  addr_update_a: assert property (@(posedge clock) disable iff (!nrst)
    cmd_wr && !cmd_word && cmd_code == vendor_regs_pkg::CMD_ADDRESS && !addr_bad && !boot
    |=> addr_ff == $past(cmd_wdata[6:0])) else $error("address not updated");
  old_addr_nack_a: assert property (@(posedge clock) disable iff (!nrst)
    bus_start && bus_target != addr_ff |=> !addr_ack) else $error("old address acknowledged");
  addr_msb_zero_a: assert property (@(posedge clock) disable iff (!nrst)
    !cmd_wr && cmd_rd && cmd_code == vendor_regs_pkg::CMD_ADDRESS |=> !cmd_rdata[7])
    else $error("address msb not zero");
  crc_after_store_a: assert property (@(posedge clock) disable iff (!nrst)
    st_ff == ST_IDLE && nvm_done |-> ##[17:18] !crc_busy) else $error("crc not finished");
  crc_ro_a: assert property (@(posedge clock) disable iff (!nrst)
    cmd_wr && cmd_code == vendor_regs_pkg::CMD_CRC |=> !cmd_ok) else $error("crc write accepted");
  off_gate_a: assert property (@(posedge clock) disable iff (!nrst)
    !conv_en |=> (detector_force & ~vendor_regs_pkg::OFF_ALLOWED) == 16'h0000)
    else $error("injection active while off");
  persist_keep_a: assert property (@(posedge clock) disable iff (!nrst)
    inject_ff[vendor_regs_pkg::BIT_FAULT_PERS] && !cmd_wr && !boot
    |=> (inject_ff & vendor_regs_pkg::FAULT_MASK) ==
        ($past(inject_ff) & vendor_regs_pkg::FAULT_MASK))
    else $error("persisted fault dropped");
  multi_force_a: assert property (@(posedge clock) disable iff (!nrst)
    conv_en |=> detector_force ==
    ($past(inject_ff) & (vendor_regs_pkg::FAULT_MASK | vendor_regs_pkg::WARN_MASK)))
    else $error("force mismatch");
  crc_run_c: cover property (@(posedge clock) disable iff (!nrst) st_ff == ST_DONE);
  addr_move_c: cover property (@(posedge clock) disable iff (!nrst) $changed(addr_ff));
  inject_c: cover property (@(posedge clock) disable iff (!nrst)
    fault_response && inject_ff != 16'h0000);

  // crc, address and injection checks
  crc_start_a: assert property (@(posedge clock) disable iff (!nrst)
    st_ff == ST_IDLE && (boot_ld_ff || nvm_done)
    |=> crc_busy) else $error("crc walk not started");
  crc_len_a: assert property (@(posedge clock) disable iff (!nrst)
    st_ff == ST_RUN && idx_ff == vendor_regs_pkg::NVM_LAST
    |=> st_ff == ST_DONE) else $error("crc walk length wrong");
  crc_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    st_ff != ST_DONE
    |=> crc_value == $past(crc_value)) else $error("crc changed outside walk");
  addr_word_a: assert property (@(posedge clock) disable iff (!nrst)
    cmd_wr && cmd_word && cmd_code == vendor_regs_pkg::CMD_ADDRESS
    |=> !cmd_ok) else $error("word write to address accepted");
  addr_read_a: assert property (@(posedge clock) disable iff (!nrst)
    cmd_rd && !cmd_wr && !cmd_word && cmd_code == vendor_regs_pkg::CMD_ADDRESS
    |=> cmd_ok && cmd_rdata[15:7] == 9'h000) else $error("address read wrong");
  ack_hold_a: assert property (@(posedge clock) disable iff (!nrst)
    !bus_start
    |=> addr_ack == $past(addr_ack)) else $error("address match changed without start");
  inject_write_a: assert property (@(posedge clock) disable iff (!nrst)
    cmd_wr && cmd_word && cmd_code == vendor_regs_pkg::CMD_INJECT
    |=> inject_ff == ($past(cmd_wdata) & vendor_regs_pkg::INJECT_WMASK))
    else $error("injection write lost");
  inject_rsv_a: assert property (@(posedge clock) disable iff (!nrst)
    (inject_ff & ~vendor_regs_pkg::INJECT_WMASK) == 16'h0000)
    else $error("reserved injection bit set");
  fault_drop_a: assert property (@(posedge clock) disable iff (!nrst)
    fault_response && !cmd_wr && !inject_ff[vendor_regs_pkg::BIT_FAULT_PERS]
    |=> (inject_ff & vendor_regs_pkg::FAULT_MASK) == 16'h0000) else $error("fault not dropped");
  warn_drop_a: assert property (@(posedge clock) disable iff (!nrst)
    warn_response && !cmd_wr && !inject_ff[vendor_regs_pkg::BIT_WARN_PERS]
    |=> (inject_ff & vendor_regs_pkg::WARN_MASK) == 16'h0000) else $error("warning not dropped");
  boot_walk_c: cover property (@(posedge clock) disable iff (!nrst)
    boot_ld_ff && st_ff == ST_IDLE);
  warn_keep_c: cover property (@(posedge clock) disable iff (!nrst)
    warn_response && inject_ff[vendor_regs_pkg::BIT_WARN_PERS]);
endmodule

/* File: src/vendor_regs_pkg.sv */
// constants for the vendor command register bank
package vendor_regs_pkg;
  localparam logic [7:0]  CMD_ADDRESS     = 8'hEF;
  localparam logic [7:0]  CMD_CRC         = 8'hF0;
  localparam logic [7:0]  CMD_INJECT      = 8'hF1;
  localparam logic [6:0]  RSV_ADDR_0      = 7'h0C;
  localparam logic [6:0]  RSV_ADDR_1      = 7'h28;
  localparam logic [6:0]  RSV_ADDR_2      = 7'h37;
  localparam logic [6:0]  RSV_ADDR_3      = 7'h61;
  localparam logic [15:0] CRC_POLY        = 16'h8005;
  localparam logic [15:0] CRC_INIT        = 16'h0000;
  localparam logic [15:0] INJECT_RESET    = 16'h0000;
  localparam logic [15:0] INJECT_WMASK    = 16'hDF9B;
  localparam logic [15:0] FAULT_MASK      = 16'h7F00;
  localparam logic [15:0] WARN_MASK       = 16'h007F;
  localparam logic [15:0] OFF_ALLOWED     = 16'h0900;
  localparam int          BIT_FAULT_PERS  = 15;
  localparam int          BIT_WARN_PERS   = 7;
  localparam int          NVM_WORDS       = 16;
  localparam int          NVM_AW          = 4;
  localparam logic [3:0]  NVM_LAST        = 4'hF;
endpackage

/* File: src/crc16_step.sv */
// one byte of crc-16 update, msb first
`timescale 1ns/10ps
module crc16_step
(
  input  wire logic [15:0] crc_in,
  input  wire logic [7:0]  data_in,
  output logic      [15:0] crc_out
);
  always_comb
  begin
    logic [15:0] c;
    c = crc_in;
    for (int i = 7; i >= 0; i--)
    begin
      if (c[15] ^ data_in[i])
        c = {c[14:0], 1'b0} ^ vendor_regs_pkg::CRC_POLY;
      else
        c = {c[14:0], 1'b0};
    end
    crc_out = c;
  end
endmodule

/* File: dv/settings_store_model.sv */
// settings store model answering byte reads in the same cycle
`timescale 1ns/10ps
module settings_store_model
(
  input  wire logic [3:0] nvm_rd_idx,
  input  wire logic [7:0] seed,
  output logic      [7:0] nvm_rd_data
);
  // content pattern, changed by seed
  assign nvm_rd_data = {nvm_rd_idx, ~nvm_rd_idx} ^ seed;
endmodule

/* File: dv/test_vendor_cmd_regs.sv */
// testbench for the vendor command register bank
`timescale 1ns/10ps
`define chk(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end
module test_vendor_cmd_regs;
  logic        clock = 1'b0;
  logic        nrst, use_strap, bus_start, cmd_wr, cmd_rd, cmd_word, conv_en, ok;
  wire         boot, nvm_done, fault_response, warn_response;
  logic        addr_ack, cmd_ok, addr_ff_out, crc_busy;
  logic [3:0]  evt, nvm_rd_idx;
  logic [6:0]  strap_addr, nvm_addr, bus_target;
  logic [7:0]  cmd_code, nvm_rd_data, seed;
  logic [15:0] cmd_wdata, cmd_rdata, crc_value, detector_force, rd;
  int          fails = 0;
  int          checks = 0;
  localparam logic [6:0] RSV [4] = '{vendor_regs_pkg::RSV_ADDR_0, vendor_regs_pkg::RSV_ADDR_1,
                                     vendor_regs_pkg::RSV_ADDR_2, vendor_regs_pkg::RSV_ADDR_3};
  assign {warn_response, fault_response, nvm_done, boot} = evt;
  always #5 clock = ~clock;
  vendor_cmd_regs vendor_cmd_regs_inst (.clock(clock), .nrst(nrst), .boot(boot),
    .use_strap(use_strap), .strap_addr(strap_addr), .nvm_addr(nvm_addr), .nvm_done(nvm_done),
    .nvm_rd_idx(nvm_rd_idx), .nvm_rd_data(nvm_rd_data), .bus_start(bus_start),
    .bus_target(bus_target), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
    .cmd_word(cmd_word), .cmd_wdata(cmd_wdata), .conv_en(conv_en),
    .fault_response(fault_response), .warn_response(warn_response), .addr_ack(addr_ack),
    .cmd_rdata(cmd_rdata), .cmd_ok(cmd_ok), .addr_ff_out(addr_ff_out), .crc_value(crc_value),
    .crc_busy(crc_busy), .detector_force(detector_force));
  settings_store_model settings_store_model_inst (.nvm_rd_idx(nvm_rd_idx), .seed(seed),
    .nvm_rd_data(nvm_rd_data));
  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [15:0] exp_crc(input logic [7:0] s);
    logic [15:0] c;
    logic [3:0]  i;
    c = 16'h0000;
    for (int n = 0; n < 16; n++)
    begin
      i = 4'(n);
      c = c ^ {({i, ~i} ^ s), 8'h00};
      for (int b = 0; b < 8; b++)
        c = c[15] ? ((c << 1) ^ vendor_regs_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
  task automatic access(input logic wr, input logic [7:0] code, input logic word,
                        input logic [15:0] data);
    @(posedge clock);
    cmd_wr <= wr;
    cmd_rd <= ~wr;
    cmd_code <= code;
    cmd_word <= word;
    cmd_wdata <= data;
    @(posedge clock);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
    ok = 1'b0;
    repeat (2)
    begin
      #1;
      ok = ok | (cmd_ok === 1'b1);
      @(posedge clock);
    end
    #1;
    rd = cmd_rdata;
  endtask
  task automatic pulse(input logic [3:0] v);
    @(posedge clock);
    evt <= v;
    @(posedge clock);
    evt <= 4'h0;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic probe(input logic [6:0] t, input logic e);
    @(posedge clock);
    bus_start <= 1'b1;
    bus_target <= t;
    @(posedge clock);
    bus_start <= 1'b0;
    @(posedge clock);
    #1;
    `chk(addr_ack, e)
  endtask
  task automatic crc_check(input logic [7:0] s);
    int n;
    n = 0;
    `chk(crc_busy, 1'b1)
    while (crc_busy !== 1'b0 && n < 40)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n == 40)
    begin
      fails++;
      end_sim();
    end
    access(1'b0, vendor_regs_pkg::CMD_CRC, 1'b1, 16'h0000);
    `chk(rd, exp_crc(s))
    `chk(crc_value, exp_crc(s))
  endtask
  initial
  begin
    nrst = 1'b0;
    evt = 4'h0;
    use_strap = 1'b0;
    strap_addr = 7'h13;
    nvm_addr = 7'h5A;
    bus_start = 1'b0;
    bus_target = 7'h00;
    {cmd_wr, cmd_rd, cmd_word, conv_en} = 4'h0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
    seed = 8'h00;
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    pulse(4'h1);
    crc_check(8'h00);
    access(1'b0, vendor_regs_pkg::CMD_ADDRESS, 1'b0, 16'h0000);
    `chk(rd[7:0], 8'h5A)
    probe(7'h5A, 1'b1);
    @(posedge clock);
    use_strap <= 1'b1;
    pulse(4'h1);
    crc_check(8'h00);
    access(1'b0, vendor_regs_pkg::CMD_ADDRESS, 1'b0, 16'h0000);
    `chk(rd[7:0], 8'h13)
    `chk(addr_ff_out, 1'b1)
    $display("test boot done");
    access(1'b1, vendor_regs_pkg::CMD_ADDRESS, 1'b0, 16'h00A2);
    `chk(ok, 1'b1)
    access(1'b0, vendor_regs_pkg::CMD_ADDRESS, 1'b0, 16'h0000);
    `chk(rd[7:0], 8'h22)
    `chk(addr_ff_out, 1'b0)
    probe(7'h22, 1'b1);
    probe(7'h13, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      access(1'b1, vendor_regs_pkg::CMD_ADDRESS, 1'b0, {9'h000, RSV[i]});
      `chk(ok, 1'b0)
      access(1'b0, vendor_regs_pkg::CMD_ADDRESS, 1'b0, 16'h0000);
      `chk(rd[7:0], 8'h22)
    end
    probe(7'h22, 1'b1);
    access(1'b1, vendor_regs_pkg::CMD_CRC, 1'b1, 16'h1234);
    `chk(ok, 1'b0)
    access(1'b0, vendor_regs_pkg::CMD_CRC, 1'b0, 16'h0000);
    `chk(ok, 1'b0)
    access(1'b1, vendor_regs_pkg::CMD_ADDRESS, 1'b1, 16'h0033);
    `chk(ok, 1'b0)
    $display("test address done");
    @(posedge clock);
    seed <= 8'h5C;
    pulse(4'h2);
    crc_check(8'h5C);
    $display("test crc done");
    access(1'b1, vendor_regs_pkg::CMD_INJECT, 1'b0, 16'h0100);
    `chk(ok, 1'b0)
    access(1'b1, vendor_regs_pkg::CMD_INJECT, 1'b1, 16'hFFFF);
    access(1'b0, vendor_regs_pkg::CMD_INJECT, 1'b1, 16'h0000);
    `chk(rd, 16'hDF9B)
    `chk(detector_force, 16'h0900)
    pulse(4'h4);
    `chk(detector_force, 16'h0900)
    @(posedge clock);
    conv_en <= 1'b1;
    pulse(4'h0);
    `chk(detector_force, 16'h5F1B)
    pulse(4'hC);
    `chk(detector_force, 16'h5F1B)
    access(1'b1, vendor_regs_pkg::CMD_INJECT, 1'b1, 16'h5F1B);
    pulse(4'h4);
    `chk(detector_force, 16'h001B)
    pulse(4'h8);
    `chk(detector_force, 16'h0000)
    $display("test inject done");
    end_sim();
  end
endmodule
